// file: scg_regs.svh
// Register offsets, field positions, reset values and timing counts of the clock generator.
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH
`define SCG_ADDR_PIN_MODE   20'hF_FFA0
`define SCG_ADDR_OSC_STOP   20'hF_FFA1
`define SCG_ADDR_MAIN_SEL   20'hF_FFA4
`define SCG_PIN_MODE_RST    8'h00
`define SCG_OSC_STOP_RST    8'h80
`define SCG_MAIN_SEL_RST    8'h00
`define SCG_BIT_EXT_CLK     7
`define SCG_BIT_PIN_SEL     6
`define SCG_BIT_GAIN        0
`define SCG_BIT_HS_STOP     7
`define SCG_BIT_OSC_STOP    0
`define SCG_BIT_CHOICE      4
`define SCG_BIT_STATUS      5
`define SCG_BIT_WDOG_EN     4
`define SCG_BIT_WDOG_STBY   0
`define SCG_SYNC_STAGES     2
`endif

// file: scg_pkg.sv
// Types shared by the clock generator files.
package scg_pkg;
    typedef logic [7:0] scg_byte_t;
    typedef enum logic [1:0] {
        SCG_PIN_PORT = 2'b00,
        SCG_PIN_RES  = 2'b01,
        SCG_PIN_EXT  = 2'b11
    } scg_pin_mode_e;
    typedef enum logic [3:0] {
        SCG_SW_ONCHIP = 4'b0001,
        SCG_SW_TO_HS  = 4'b0010,
        SCG_SW_HS     = 4'b0100,
        SCG_SW_TO_ON  = 4'b1000
    } scg_sw_state_e;
endpackage

// file: scg_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
module scg_sync (
    input  wire logic clk,   // System clock.
    input  wire logic nrst,  // Asynchronous reset, active low.
    input  wire logic ce,    // Clock enable.
    input  wire logic d,     // Asynchronous level in.
    output logic      q      // Synchronised level out.
);
    logic meta_q;

    // The first flop feeds only the second one.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// file: scg_clock_gen.sv
// Main clock select, oscillator gating and clock registers of the clock generator.
`timescale 1ns/1ps
`include "scg_regs.svh"
module scg_clock_gen (
    input  wire logic               clk,             // System clock, 50 MHz.
    input  wire logic               nrst,            // Asynchronous reset, active low.
    input  wire logic               ce,              // Clock enable, freezes all state.
    input  wire logic [19:0]        addr,            // Register address.
    input  wire scg_pkg::scg_byte_t wdata,           // Write data.
    input  wire logic               wr_en,           // Write strobe.
    input  wire logic               bit_wr,          // Write is a 1-bit access.
    input  wire logic [2:0]         bit_pos,         // Bit position for 1-bit access.
    input  wire logic               rd_en,           // Read strobe.
    input  wire logic               stop_instr,      // Stop instruction executing.
    input  wire logic               halt_instr,      // Halt instruction executing.
    input  wire logic               wdog_enable_option,  // Option byte watchdog enable.
    input  wire logic               wdog_standby_run,    // Option byte standby run.
    input  wire logic               interval_timer_lowclk_sel, // Interval timer low clock.
    input  wire logic [2:0]         freq_option,     // Option byte frequency code.
    input  wire logic [2:0]         onchip_osc_freq_select, // Run-time frequency code.
    input  wire logic               freq_sel_wr,     // Frequency code written.
    input  wire logic               hs_clk_ready,    // Hs clock present (async).
    output scg_pkg::scg_byte_t      rdata,           // Read data.
    output logic                    hs_osc_en,       // Resonator oscillator enable.
    output logic                    ext_clk_in_en,   // External clock input enable.
    output logic                    osc_gain_high,   // Resonator high-gain range.
    output logic [1:0]              pin_mode,        // Pin operating mode.
    output logic                    onchip_osc_en,   // On-chip oscillator enable.
    output logic [2:0]              onchip_freq,     // On-chip oscillator frequency code.
    output logic                    lowspd_osc_en,   // Low-speed oscillator enable.
    output logic                    main_sel_hs,     // Main and peripheral clock is hs.
    output logic                    cpu_clk_lowspd   // Always 0: low-speed never clocks CPU.
);
    import scg_pkg::*;

    scg_byte_t     pin_q, pin_d;
    logic          pin_lock_q;
    scg_byte_t     stop_q, stop_d;
    logic          choice_q, choice_d;
    scg_sw_state_e sw_q, sw_d;
    logic [2:0]    freq_q;
    logic          freq_init_q;
    logic          hs_ready_s;
    logic          hs_en_q, ext_en_q, on_en_q, lo_en_q, sel_q;

    // Address decode and write qualifiers.
    wire hit_pin  = (addr == `SCG_ADDR_PIN_MODE);
    wire hit_stop = (addr == `SCG_ADDR_OSC_STOP);
    wire hit_sel  = (addr == `SCG_ADDR_MAIN_SEL);
    wire wr_pin   = wr_en && hit_pin && !bit_wr && !pin_lock_q;
    wire wr_stop  = wr_en && hit_stop;
    wire wr_sel   = wr_en && hit_sel;
    wire [7:0] bit_mask = 8'h01 << bit_pos;
    wire [1:0] pin_bits = {pin_q[`SCG_BIT_EXT_CLK], pin_q[`SCG_BIT_PIN_SEL]};
    wire status_hs = (sw_q == SCG_SW_HS) || (sw_q == SCG_SW_TO_ON);

    // Merge 1-bit or 8-bit writes into the stop and select registers.
    // Stop register write paths.
    always_comb begin
        pin_d    = wr_pin ? wdata : pin_q;
        stop_d   = stop_q;
        choice_d = choice_q;
        if (wr_stop) begin
            stop_d = bit_wr ? ((stop_q & ~bit_mask) | (wdata & bit_mask)) : wdata;
            stop_d = stop_d & 8'h81;
        end
        // Only the choice bit is writable.
        if (wr_sel) begin
            if (!bit_wr) begin
                choice_d = wdata[`SCG_BIT_CHOICE];
            end else if (bit_pos == 3'(`SCG_BIT_CHOICE)) begin
                choice_d = wdata[`SCG_BIT_CHOICE];
            end
        end
    end

    // Register file state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_q      <= `SCG_PIN_MODE_RST;
            pin_lock_q <= 1'b0;
            stop_q     <= `SCG_OSC_STOP_RST;
            choice_q   <= 1'b0;
        end else if (ce) begin
            pin_q      <= pin_d;
            pin_lock_q <= pin_lock_q | (wr_en && hit_pin && !bit_wr);
            stop_q     <= stop_d;
            choice_q   <= choice_d;
        end
    end

    // Hs clock presence crosses in through two flops.
    scg_sync u_sync (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .d    (hs_clk_ready),
        .q    (hs_ready_s)
    );

    // Switch FSM: the old source is released before the new one is taken,
    // so the main clock never sees a runt pulse.
    // Status follows the completed switch only.
    always_comb begin
        sw_d = sw_q;
        unique case (sw_q)
            SCG_SW_ONCHIP: if (choice_q) sw_d = SCG_SW_TO_HS;
            SCG_SW_TO_HS:  if (!choice_q) sw_d = SCG_SW_ONCHIP;
                           else if (hs_ready_s) sw_d = SCG_SW_HS;
            SCG_SW_HS:     if (!choice_q) sw_d = SCG_SW_TO_ON;
            SCG_SW_TO_ON:  sw_d = SCG_SW_ONCHIP;
            default:       sw_d = SCG_SW_ONCHIP;
        endcase
    end

    // Reset always restarts from the on-chip oscillator.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_q <= SCG_SW_ONCHIP;
        end else if (ce) begin
            sw_q <= sw_d;
        end
    end

    // On-chip frequency: option code at first enabled edge, then software.
    // Option byte load.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            freq_q      <= 3'h0;
            freq_init_q <= 1'b0;
        end else if (ce) begin
            freq_init_q <= 1'b1;
            if (!freq_init_q) begin
                freq_q <= freq_option;
            end else if (freq_sel_wr) begin
                freq_q <= onchip_osc_freq_select;
            end
        end
    end

    // Hs stop on instruction or bit 7.
    wire hs_run   = !stop_instr && !stop_q[`SCG_BIT_HS_STOP];
    wire res_mode = (pin_bits == SCG_PIN_RES);
    wire ext_mode = (pin_bits == SCG_PIN_EXT);
    // Code 10 folds into port mode, so the pin logic never sees an undefined mode.
    wire [1:0] pin_dec = res_mode ? SCG_PIN_RES : (ext_mode ? SCG_PIN_EXT : SCG_PIN_PORT);
    // On-chip stop on instruction or bit 0.
    // Bit 0 high stops the oscillator.
    wire on_run   = !stop_instr && !stop_q[`SCG_BIT_OSC_STOP];
    // Watchdog-only use without standby run stops in halt or stop.
    wire lo_want  = wdog_enable_option || interval_timer_lowclk_sel;
    wire lo_sleep = wdog_enable_option && !interval_timer_lowclk_sel &&
                    !wdog_standby_run && (halt_instr || stop_instr);
    // Peripheral clock follows main clock in the same cycle.
    wire sel_d    = (sw_d == SCG_SW_HS);

    // Registered enables so every output comes from a flop.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hs_en_q  <= 1'b0;
            ext_en_q <= 1'b0;
            on_en_q  <= 1'b1;
            lo_en_q  <= 1'b0;
            sel_q    <= 1'b0;
        end else if (ce) begin
            hs_en_q  <= hs_run && res_mode;
            ext_en_q <= hs_run && ext_mode;
            on_en_q  <= on_run;
            lo_en_q  <= lo_want && !lo_sleep;
            sel_q    <= sel_d;
        end
    end

    // Register read mux; unmapped addresses read zero.
    // Status bit 5 is read-only.
    wire [7:0] sel_rd = {2'b00, status_hs, choice_q, 4'h0};
    wire [7:0] rd_mux = hit_pin ? pin_q : hit_stop ? stop_q : hit_sel ? sel_rd : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (ce && rd_en) begin
            rdata <= rd_mux;
        end
    end

    // Gain bit passed to the resonator.
    // Low-speed clock is never a CPU source.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_gain_high  <= 1'b0;
            pin_mode       <= 2'b00;
            cpu_clk_lowspd <= 1'b0;
        end else if (ce) begin
            osc_gain_high  <= pin_q[`SCG_BIT_GAIN];
            pin_mode       <= pin_dec;
            cpu_clk_lowspd <= 1'b0;
        end
    end

    assign hs_osc_en     = hs_en_q;
    assign ext_clk_in_en = ext_en_q;
    assign onchip_osc_en = on_en_q;
    assign lowspd_osc_en = lo_en_q;
    assign main_sel_hs   = sel_q;
    assign onchip_freq   = freq_q;

    // Assertions.
    a_pin_once: assert property (@(posedge clk) disable iff (!nrst)
        (ce && pin_lock_q && wr_en && hit_pin) |=> $stable(pin_q))
        else $error("Pin-mode register changed after lock.");
    a_hs_stop: assert property (@(posedge clk) disable iff (!nrst)
        (ce && stop_instr) |=> (!hs_osc_en && !ext_clk_in_en))
        else $error("Hs clock runs during stop.");
    a_on_stop: assert property (@(posedge clk) disable iff (!nrst)
        (ce && stop_q[`SCG_BIT_OSC_STOP]) |=> !onchip_osc_en)
        else $error("On-chip oscillator runs while stopped.");
    a_port_mode: assert property (@(posedge clk) disable iff (!nrst)
        (ce && pin_bits[0] == 1'b0) |=> (!hs_osc_en && !ext_clk_in_en))
        else $error("Hs clock enabled in port mode.");
    a_lo_sleep: assert property (@(posedge clk) disable iff (!nrst)
        (ce && lo_sleep) |=> !lowspd_osc_en)
        else $error("Low-speed oscillator runs in sleep.");
    a_lo_run: assert property (@(posedge clk) disable iff (!nrst)
        (ce && lo_want && !lo_sleep) |=> lowspd_osc_en)
        else $error("Low-speed oscillator not running.");
    a_status_late: assert property (@(posedge clk) disable iff (!nrst)
        (ce && sw_q == SCG_SW_ONCHIP && choice_q) |=> !status_hs)
        else $error("Status set before switch completed.");
    a_sel_reg: assert property (@(posedge clk) disable iff (!nrst)
        (ce && wr_sel && !bit_wr) |=> (choice_q == $past(wdata[`SCG_BIT_CHOICE])))
        else $error("Main select choice not stored.");
    a_no_lowspd: assert property (@(posedge clk) disable iff (!nrst)
        !cpu_clk_lowspd)
        else $error("Low-speed clock drives CPU.");
    a_stop_bit7: assert property (@(posedge clk) disable iff (!nrst)
        (ce && stop_q[`SCG_BIT_HS_STOP]) |=> (!hs_osc_en && !ext_clk_in_en))
        else $error("Hs clock runs while its stop bit is set.");
    a_on_main: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !choice_q && sw_q != SCG_SW_HS) |=> !main_sel_hs)
        else $error("Hs clock is main without being chosen.");
    a_freq_load: assert property (@(posedge clk) disable iff (!nrst)
        (ce && freq_init_q && freq_sel_wr) |=> (onchip_freq == $past(onchip_osc_freq_select)))
        else $error("Frequency override not taken.");
    a_pin_decode: assert property (@(posedge clk) disable iff (!nrst)
        (ce && pin_bits == 2'h2) |=> (pin_mode == SCG_PIN_PORT))
        else $error("Pin code 10 not reported as port mode.");
    a_sel_bit: assert property (@(posedge clk) disable iff (!nrst)
        (ce && wr_sel && bit_wr && bit_pos == 3'h4) |=> (choice_q == $past(wdata[`SCG_BIT_CHOICE])))
        else $error("Main select bit write not stored.");
    a_rd_status: assert property (@(posedge clk) disable iff (!nrst)
        (ce && rd_en && hit_sel) |=> (rdata[`SCG_BIT_STATUS] == $past(status_hs)))
        else $error("Status bit read does not match the switch state.");
    a_stop_reg: assert property (@(posedge clk) disable iff (!nrst)
        (ce && wr_stop && !bit_wr) |=> (stop_q == ($past(wdata) & 8'h81)))
        else $error("Stop register byte write not stored.");
    a_hs_wait: assert property (@(posedge clk) disable iff (!nrst)
        (ce && sw_q == SCG_SW_TO_HS && !hs_ready_s) |=> !main_sel_hs)
        else $error("Main clock switched before hs clock was ready.");

    c_switch_hs: cover property (@(posedge clk) sw_q == SCG_SW_HS);
    c_switch_back: cover property (@(posedge clk) sw_q == SCG_SW_TO_ON);
    c_pin_lock: cover property (@(posedge clk) pin_lock_q && wr_en && hit_pin);
    c_pin_ext: cover property (@(posedge clk) ext_clk_in_en);
    c_lo_sleep: cover property (@(posedge clk) lo_sleep && !lowspd_osc_en);
endmodule

// file: scg_xtal_model.sv
// Behavioural model of the crystal resonator or external clock source on the hs pins.
`timescale 1ns/1ps
module scg_xtal_model #(
    parameter int FAST_NS = 200,   // Settling time of a quick part.
    parameter int SLOW_NS = 1500   // Settling time of a sluggish part.
) (
    input  wire logic hs_osc_en,      // Resonator oscillator enable from the block.
    input  wire logic ext_clk_in_en,  // External clock input enable from the block.
    input  wire logic slow,           // Selects the slow settling time.
    output logic      hs_clk_ready    // Clock is present and stable.
);
    int settle;

    // Stable only after settling.
    // Ready rises only after an unbroken settling span; any drop of the enable restarts it.
    // The extra 5 ns keep the rise away from the block's sampling edge.
    always begin
        hs_clk_ready = 1'b0;
        wait (hs_osc_en || ext_clk_in_en);
        settle = 0;
        while (settle < (slow ? SLOW_NS : FAST_NS) + 5 && (hs_osc_en || ext_clk_in_en)) begin
            #1;
            settle++;
        end
        if (hs_osc_en || ext_clk_in_en) begin
            hs_clk_ready = 1'b1;
            wait (!(hs_osc_en || ext_clk_in_en));
        end
    end
endmodule

// file: tb.sv
// Self-checking bench for the clock generator register and gating behaviour.
`timescale 1ns/1ps
`include "scg_regs.svh"
module tb;
    logic               clk, nrst, ce, wr_en, bit_wr, rd_en, stop_instr, halt_instr, slow;
    logic               wdog_enable_option, wdog_standby_run, interval_timer_lowclk_sel;
    logic               freq_sel_wr, hs_clk_ready, hs_osc_en, ext_clk_in_en, osc_gain_high;
    logic               onchip_osc_en, lowspd_osc_en, main_sel_hs, cpu_clk_lowspd;
    logic [19:0]        addr;
    scg_pkg::scg_byte_t wdata, rdata;
    logic [2:0]         bit_pos, freq_option, onchip_osc_freq_select, onchip_freq;
    logic [1:0]         pin_mode;
    logic [7:0]         modes [4] = '{8'h00, 8'h81, 8'hC0, 8'h41};
    logic [1:0]         exp_pm [4] = '{2'b00, 2'b00, 2'b11, 2'b01};
    int                 n_fail = 0;
    int                 total_checks = 0;
    logic               w, l, s, h;

    scg_clock_gen DUT (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .bit_wr(bit_wr), .bit_pos(bit_pos), .rd_en(rd_en),
        .stop_instr(stop_instr), .halt_instr(halt_instr),
        .wdog_enable_option(wdog_enable_option), .wdog_standby_run(wdog_standby_run),
        .interval_timer_lowclk_sel(interval_timer_lowclk_sel), .freq_option(freq_option),
        .onchip_osc_freq_select(onchip_osc_freq_select), .freq_sel_wr(freq_sel_wr),
        .hs_clk_ready(hs_clk_ready), .rdata(rdata), .hs_osc_en(hs_osc_en),
        .ext_clk_in_en(ext_clk_in_en), .osc_gain_high(osc_gain_high), .pin_mode(pin_mode),
        .onchip_osc_en(onchip_osc_en), .onchip_freq(onchip_freq),
        .lowspd_osc_en(lowspd_osc_en), .main_sel_hs(main_sel_hs),
        .cpu_clk_lowspd(cpu_clk_lowspd));

    scg_xtal_model XTAL (.hs_osc_en(hs_osc_en), .ext_clk_in_en(ext_clk_in_en), .slow(slow),
        .hs_clk_ready(hs_clk_ready));

    // Free-running 50 MHz system clock.
    always #10 clk = ~clk;

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // All bus tasks start and end at a falling edge, so the rising edge takes stable inputs.
    // The idle cycle at the end keeps back-to-back calls from driving the strobe twice at once.
    task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic bw,
                      input logic [2:0] bp);
        addr = a; wdata = d; bit_wr = bw; bit_pos = bp; wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0; bit_wr = 1'b0;
        @(negedge clk);
    endtask

    // Read data is registered, so it is looked at one cycle after the read is taken.
    task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
        addr = a; rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        @(negedge clk);
        chk(rdata, exp, "register read");
    endtask

    // Waits a bounded time for the main clock changeover to settle.
    task automatic wait_main(input logic e);
        for (int i = 0; i < 200 && main_sel_hs !== e; i++) @(negedge clk);
        chk({7'b0, main_sel_hs}, {7'b0, e}, "main clock switch");
    endtask

    // Holds reset low for 16 cycles and releases it away from the sampling edge.
    task automatic do_reset();
        nrst = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog reckoned well beyond the roughly 300 cycles the tests need.
    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        clk = 0; nrst = 0; ce = 1; addr = '0; wdata = '0; wr_en = 0; bit_wr = 0; bit_pos = '0;
        rd_en = 0; stop_instr = 0; halt_instr = 0; slow = 0; wdog_enable_option = 0;
        wdog_standby_run = 0; interval_timer_lowclk_sel = 0; freq_option = 3'd2;
        onchip_osc_freq_select = '0; freq_sel_wr = 0;
        // Pin modes and gain, one reset each, since the pin register is write-once.
        for (int m = 0; m < 4; m++) begin
            do_reset();
            if (m == 0) begin
                chk({5'b0, onchip_freq}, 8'h02, "option frequency");
                chk({7'b0, onchip_osc_en}, 8'h01, "onchip after reset");
                chk({7'b0, main_sel_hs}, 8'h00, "main after reset");
                rd_chk(`SCG_ADDR_PIN_MODE, `SCG_PIN_MODE_RST);
                rd_chk(`SCG_ADDR_OSC_STOP, `SCG_OSC_STOP_RST);
                rd_chk(`SCG_ADDR_MAIN_SEL, `SCG_MAIN_SEL_RST);
                rd_chk(20'hF_FFA2, 8'h00);
            end
            // Pin mode is set while the hs stop bit still holds its reset value of 1.
            wr(`SCG_ADDR_PIN_MODE, modes[m], 1'b0, 3'd0);
            wr(`SCG_ADDR_PIN_MODE, 8'hFF, 1'b0, 3'd0);
            wr(`SCG_ADDR_OSC_STOP, 8'h00, 1'b1, 3'd7);
            repeat (2) @(negedge clk);
            rd_chk(`SCG_ADDR_PIN_MODE, modes[m]);
            chk({6'b0, pin_mode}, {6'b0, exp_pm[m]}, "pin mode");
            chk({7'b0, osc_gain_high}, {7'b0, modes[m][0]}, "gain");
            chk({7'b0, hs_osc_en}, {7'b0, exp_pm[m] == 2'b01}, "resonator enable");
            chk({7'b0, ext_clk_in_en}, {7'b0, exp_pm[m] == 2'b11}, "ext enable");
        end
        // Switch to the hs clock with a slow part; status waits for the changeover.
        wr(`SCG_ADDR_OSC_STOP, 8'h80, 1'b0, 3'd0);
        slow = 1'b1;
        repeat (2) @(negedge clk);
        wr(`SCG_ADDR_OSC_STOP, 8'h00, 1'b0, 3'd0);
        repeat (3) @(negedge clk);
        chk({7'b0, hs_osc_en}, 8'h01, "hs restarted");
        // Software polls for a settled hs clock before choosing it as main clock.
        for (int i = 0; i < 100 && hs_clk_ready !== 1'b1; i++) @(negedge clk);
        wr(`SCG_ADDR_MAIN_SEL, 8'h10, 1'b0, 3'd0);
        chk({7'b0, main_sel_hs}, 8'h00, "early switch");
        rd_chk(`SCG_ADDR_MAIN_SEL, 8'h10);
        wait_main(1'b1);
        rd_chk(`SCG_ADDR_MAIN_SEL, 8'h30);
        // Stop the on-chip oscillator while the hs clock is main; bits 6:1 are ignored.
        wr(`SCG_ADDR_OSC_STOP, 8'h7F, 1'b0, 3'd0);
        rd_chk(`SCG_ADDR_OSC_STOP, 8'h01);
        chk({7'b0, onchip_osc_en}, 8'h00, "onchip stopped");
        wr(`SCG_ADDR_OSC_STOP, 8'h00, 1'b1, 3'd0);
        repeat (2) @(negedge clk);
        chk({7'b0, onchip_osc_en}, 8'h01, "onchip running");
        wr(`SCG_ADDR_MAIN_SEL, 8'h00, 1'b1, 3'd4);
        wait_main(1'b0);
        // Status still shows hs for the release cycle after the main select drops.
        @(negedge clk);
        rd_chk(`SCG_ADDR_MAIN_SEL, 8'h00);
        // The stop instruction halts both fast oscillators until it ends.
        stop_instr = 1'b1;
        repeat (2) @(negedge clk);
        chk({6'b0, hs_osc_en, onchip_osc_en}, 8'h00, "stop instruction");
        stop_instr = 1'b0;
        repeat (2) @(negedge clk);
        chk({6'b0, hs_osc_en, onchip_osc_en}, 8'h03, "stop released");
        // Run-time frequency override.
        onchip_osc_freq_select = 3'd4;
        freq_sel_wr = 1'b1;
        @(negedge clk);
        freq_sel_wr = 1'b0;
        repeat (2) @(negedge clk);
        chk({5'b0, onchip_freq}, 8'h04, "frequency override");
        // With the clock enable low a write must not land.
        ce = 1'b0;
        wr(`SCG_ADDR_MAIN_SEL, 8'h10, 1'b0, 3'd0);
        ce = 1'b1;
        rd_chk(`SCG_ADDR_MAIN_SEL, 8'h00);
        // Low-speed oscillator gating over every option and standby combination.
        for (int i = 0; i < 32; i++) begin
            {w, l, s, h} = i[3:0];
            wdog_enable_option = w; interval_timer_lowclk_sel = l; wdog_standby_run = s;
            halt_instr = h & ~i[4]; stop_instr = h & i[4];
            repeat (2) @(negedge clk);
            chk({7'b0, lowspd_osc_en}, {7'b0, (w | l) & ~(w & ~l & ~s & h)}, "lowspd");
            chk({7'b0, cpu_clk_lowspd}, 8'h00, "lowspd cpu");
        end
        print_verdict();
    end
endmodule
